// ---- inc/srf_pkg.sv ----
package srf_pkg;
    // ----------------------------------------------------------------
    // clock and time
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_TIME_NS = 1_000_000;
    localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int SUP_TIME_MS = 3000;
    localparam int UNIT10_MS = 10;
    localparam int IDLE_CHARS = 3;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_PRM = 12'h000;
    localparam logic [11:0] ADDR_CFG = 12'h004;
    localparam logic [11:0] ADDR_REQ = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [11:0] ADDR_DIAG = 12'h010;
    localparam logic [11:0] ADDR_HDR = 12'h014;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PRM_BAUD = 0;
    localparam int PRM_PAR = 3;
    localparam int PRM_BITS8 = 5;
    localparam int PRM_ENDC = 6;
    localparam int PRM_FIXLEN = 9;
    localparam int PRM_TUNIT = 10;
    localparam int PRM_SUP = 11;
    localparam int PRM_W = 13;
    localparam int CFG_IN = 0;
    localparam int CFG_OUT = 8;
    localparam int CFG_SET_PRES = 16;
    localparam int CFG_SET_FIRST = 17;
    localparam int REQ_CMD = 0;
    localparam int REQ_TMO = 8;
    localparam int REQ_RLEN = 16;
    localparam int REQ_TMO_GIVEN = 24;
    localparam int REQ_RLEN_GIVEN = 25;
    localparam int HDR_LEN = 3;
    localparam int MAX_IO = 128;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] END_NONE = 3'h0;
    localparam logic [2:0] END_CR = 3'h1;
    localparam logic [2:0] END_LF = 3'h2;
    localparam logic [2:0] END_CRLF = 3'h3;
    localparam logic [2:0] END_LFCR = 3'h4;
    localparam logic [7:0] CHR_CR = 8'h0d;
    localparam logic [7:0] CHR_LF = 8'h0a;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_MAX = 2'h2;
    localparam logic [1:0] SUP_OFF = 2'h0;
    localparam logic [1:0] SUP_REQ = 2'h1;
    localparam logic [1:0] SUP_CYC = 2'h2;
    localparam logic [7:0] CNT_FIRST = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // diagnostic flag positions
    localparam int DG_SET_ERR = 0;
    localparam int DG_OUT_OVF = 1;
    localparam int DG_OUT_LOSS = 2;
    localparam int DG_IN_OVF = 3;
    localparam int DG_IN_LOSS = 4;
    localparam int DG_IN_TMO = 5;
    localparam int DG_W = 6;
    // transfer state bit: bytes dropped while this string filled
    localparam int TS_OVF = 0;

    typedef enum logic [2:0] {
        ST_WAIT_PRM = 3'b001,
        ST_WAIT_CFG = 3'b010,
        ST_DATA_EX = 3'b100
    } srf_state_e;

    // cycles per serial bit for each baud selection
    function automatic logic [23:0] srf_bit_div(input logic [2:0] sel);
        int rate;
        case (sel)
            3'h0: rate = 1200;
            3'h1: rate = 2400;
            3'h2: rate = 4800;
            3'h3: rate = 9600;
            3'h4: rate = 19200;
            3'h5: rate = 38400;
            3'h6: rate = 57600;
            default: rate = 115200;
        endcase
        return 24'(CLK_HZ / rate);
    endfunction : srf_bit_div
endpackage : srf_pkg

// ---- inc/srf_buf_if.sv ----
`timescale 1ns/1ns
// string buffer port between framer and its memory
interface srf_buf_if #(parameter int AW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : srf_buf_if

// ---- rtl/srf_buf_mem.sv ----
`timescale 1ns/1ns
// two-bank string memory, registered read
module srf_buf_mem #(
    parameter int AW = 8
) (
    // clock
    input wire logic clk,
    // buffer port
    srf_buf_if.mem bus
);
    logic [7:0] mem [0:(1<<AW)-1];

    // one write and one registered read per cycle
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem[bus.rd_addr];
    end
endmodule : srf_buf_mem

// ---- rtl/srf_framer.sv ----
`timescale 1ns/1ns
module srf_framer import srf_pkg::*; #(
    parameter int MAX_LEN = 128,
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial receive bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // serial transmit buffer state
    input wire logic tx_busy,
    // fieldbus input area read port
    input wire logic [7:0] fb_rd_addr,
    output logic [7:0] fb_rd_data,
    // indicators
    output logic led_err,
    output logic data_ex,
    output logic new_string
);
    localparam int PW = $clog2(MAX_LEN);
    localparam int AW = PW + 1;
    localparam int LW = $clog2(MAX_LEN + 1);

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_prm = paddr == ADDR_PRM;
    wire hit_cfg = paddr == ADDR_CFG;
    wire hit_req = paddr == ADDR_REQ;
    wire hit_stat = paddr == ADDR_STAT;
    wire hit_diag = paddr == ADDR_DIAG;
    wire hit_hdr = paddr == ADDR_HDR;
    wire hit_any = hit_prm | hit_cfg | hit_req | hit_stat | hit_diag | hit_hdr;
    wire wr_prm = wr & hit_prm;
    wire wr_cfg = wr & hit_cfg;
    wire wr_req = wr & hit_req;
    wire rd_diag = rd & hit_diag;

    srf_state_e state;
    srf_state_e next_state;
    logic [PRM_W-1:0] prm;
    logic [23:0] cfg;
    logic [DG_W-1:0] diag;
    logic [DG_W-1:0] next_diag;
    logic [7:0] hdr_state;
    logic [7:0] hdr_len;
    logic [7:0] hdr_cnt;

    // parameter field views
    wire [2:0] baud_sel = prm[PRM_BAUD +: 3];
    wire [1:0] par_sel = prm[PRM_PAR +: 2];
    wire bits8 = prm[PRM_BITS8];
    wire [2:0] endc = prm[PRM_ENDC +: 3];
    wire fixlen = prm[PRM_FIXLEN];
    wire tunit10 = prm[PRM_TUNIT];
    wire [1:0] sup_mode = prm[PRM_SUP +: 2];

    // read mux; one-cycle access, no wait states
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;
    assign prdata = !rd ? 32'h0000_0000 :
        hit_prm ? {{(32-PRM_W){1'b0}}, prm} :
        hit_cfg ? {8'h00, cfg} :
        hit_stat ? {28'h000_0000, led_err, state} :
        hit_diag ? {{(32-DG_W){1'b0}}, diag} :
        hit_hdr ? {8'h00, hdr_cnt, hdr_len, hdr_state} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // start-up sequencing
    // ----------------------------------------------------------------
    wire prm_ok = (pwdata[PRM_PAR +: 2] <= PAR_MAX) & (pwdata[PRM_ENDC +: 3] <= END_LFCR)
        & (pwdata[PRM_SUP +: 2] <= SUP_CYC);
    wire [7:0] w_in = pwdata[CFG_IN +: 8];
    wire [7:0] w_out = pwdata[CFG_OUT +: 8];
    wire set_ok = pwdata[CFG_SET_PRES] & pwdata[CFG_SET_FIRST];
    wire len_ok = (w_in != 8'h00) & (w_in <= 8'(MAX_IO)) & (w_out != 8'h00)
        & (w_out <= 8'(MAX_IO));
    wire cfg_ok = (state == ST_WAIT_CFG) & set_ok & len_ok;
    // any failing set-up step is an error
    wire setup_err = (wr_prm & ~prm_ok) | (wr_cfg & ~cfg_ok);

    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT_PRM: if (wr_prm & prm_ok) next_state = ST_WAIT_CFG;
            ST_WAIT_CFG: if (wr_cfg) next_state = cfg_ok ? ST_DATA_EX : ST_WAIT_PRM;
            ST_DATA_EX: if (wr_prm & prm_ok) next_state = ST_WAIT_CFG;
            default: next_state = ST_WAIT_PRM;
        endcase
        if (setup_err) next_state = ST_WAIT_PRM;
    end

    // state, stored parameters and indicator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_WAIT_PRM;
            prm <= '0;
            cfg <= '0;
            led_err <= 1'b0;
        end else begin
            state <= next_state;
            if (wr_prm & prm_ok) prm <= pwdata[PRM_W-1:0];
            if (cfg_ok & wr_cfg) cfg <= pwdata[23:0];
            if (setup_err) led_err <= 1'b1;
            else if (next_state == ST_DATA_EX) led_err <= 1'b0;
        end
    end
    assign data_ex = state == ST_DATA_EX;

    // ----------------------------------------------------------------
    // request telegram handling
    // ----------------------------------------------------------------
    logic [7:0] last_cmd;
    logic cmd_seen;
    logic [7:0] rlen;
    logic [7:0] tmo_val;
    logic tmo_have;
    wire req_take = wr_req & data_ex;
    wire [7:0] req_cmd = pwdata[REQ_CMD +: 8];

    // timeout and count kept unless a request supplies them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cmd <= 8'h00;
            cmd_seen <= 1'b0;
            rlen <= 8'h00;
            tmo_val <= 8'h00;
            tmo_have <= 1'b0;
        end else if (req_take) begin
            last_cmd <= req_cmd;
            cmd_seen <= 1'b1;
            if (pwdata[REQ_RLEN_GIVEN]) rlen <= pwdata[REQ_RLEN +: 8];
            if (pwdata[REQ_TMO_GIVEN]) begin
                tmo_val <= pwdata[REQ_TMO +: 8];
                tmo_have <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // character timing
    // ----------------------------------------------------------------
    logic [23:0] bdiv;
    logic [5:0] gap_bits;
    logic [16:0] ms_cnt;
    logic [3:0] dec10;
    logic [8:0] tmo_units;
    wire [23:0] bit_div = srf_bit_div(baud_sel);
    wire bit_tick = bdiv == bit_div - 24'h00_0001;
    wire ms_tick = ms_cnt == 17'(MS_CYCLES - 1);
    // unit of one or ten milliseconds
    wire unit_tick = ms_tick & (!tunit10 | (dec10 == 4'(UNIT10_MS - 1)));
    wire [5:0] char_bits = 6'h02 + (bits8 ? 6'h08 : 6'h07)
        + ((par_sel != PAR_NONE) ? 6'h01 : 6'h00);
    wire [5:0] idle_bits = 6'(char_bits * IDLE_CHARS);

    // bit divider restarts at every byte so gaps are measured from it; ms divider runs free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdiv <= '0;
            gap_bits <= '0;
            ms_cnt <= '0;
            dec10 <= '0;
            tmo_units <= '0;
        end else begin
            bdiv <= (bit_tick | rx_valid) ? 24'h00_0000 : bdiv + 24'h00_0001;
            ms_cnt <= ms_tick ? 17'h0_0000 : ms_cnt + 17'h0_0001;
            if (ms_tick) dec10 <= (dec10 == 4'(UNIT10_MS - 1)) ? 4'h0 : dec10 + 4'h1;
            if (rx_valid) begin
                gap_bits <= '0;
                tmo_units <= '0;
            end else begin
                if (bit_tick & (gap_bits != 6'h3f)) gap_bits <= gap_bits + 6'h01;
                if (unit_tick & (tmo_units != 9'h1ff)) tmo_units <= tmo_units + 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // string framing
    // ----------------------------------------------------------------
    logic [LW-1:0] len;
    logic [7:0] prev_byte;
    logic w_bank;
    logic str_ovf;
    wire frame_on = data_ex;
    wire take = frame_on & rx_valid;
    wire full = len == LW'(MAX_LEN);
    wire [LW-1:0] len_inc = len + LW'(1);
    wire tmo_mode = (endc == END_NONE) & ~fixlen;
    wire end_hit = (endc == END_CR & rx_data == CHR_CR)
        | (endc == END_LF & rx_data == CHR_LF)
        | (endc == END_CRLF & prev_byte == CHR_CR & rx_data == CHR_LF & len != '0)
        | (endc == END_LFCR & prev_byte == CHR_LF & rx_data == CHR_CR & len != '0);
    wire cnt_hit = fixlen & (rlen != 8'h00) & (8'(len_inc) >= rlen);
    wire byte_close = take & ~full & (end_hit | cnt_hit);
    wire tmo_exp = tmo_have ? (tmo_units > {1'b0, tmo_val}) : (gap_bits >= char_bits);
    // three idle characters end a short string
    wire idle_exp = ~tmo_mode & (gap_bits >= idle_bits);
    wire idle_close = frame_on & ~rx_valid & (len != '0) & (tmo_mode ? tmo_exp : idle_exp);
    wire close = byte_close | idle_close;
    wire [LW-1:0] close_len = byte_close ? len_inc : len;
    wire in_ovf = take & full;

    srf_buf_if #(.AW(AW)) buf_bus ();
    // payload into the filling bank; the other bank is presented
    assign buf_bus.wr_en = take & ~full;
    assign buf_bus.wr_addr = {w_bank, len[PW-1:0]};
    assign buf_bus.wr_data = rx_data;

    // fill count, bank swap and header capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len <= '0;
            prev_byte <= 8'h00;
            w_bank <= 1'b0;
            str_ovf <= 1'b0;
            hdr_state <= 8'h00;
            hdr_len <= 8'h00;
            hdr_cnt <= 8'h00;
            new_string <= 1'b0;
        end else begin
            new_string <= close;
            if (take) prev_byte <= rx_data;
            if (close) begin
                len <= '0;
                w_bank <= ~w_bank;
                str_ovf <= 1'b0;
                hdr_state <= 8'(str_ovf) << TS_OVF;
                hdr_len <= 8'(close_len);
                hdr_cnt <= (hdr_cnt == CNT_MAX) ? CNT_FIRST : hdr_cnt + 8'h01;
            end else if (take & ~full) begin
                len <= len_inc;
            end else if (in_ovf) begin
                str_ovf <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // input supervision
    // ----------------------------------------------------------------
    logic [11:0] sup_cnt;
    logic sup_run;
    wire sup_exp = sup_run & ms_tick & (sup_cnt == 12'(SUP_TIME_MS - 1));
    wire sup_req = data_ex & (sup_mode == SUP_REQ);
    wire sup_cyc = data_ex & (sup_mode == SUP_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_cnt <= '0;
            sup_run <= 1'b0;
        end else if (sup_req & req_take) begin
            sup_cnt <= '0;
            sup_run <= 1'b1;
        end else if ((sup_req & rx_valid) | ~(sup_req | sup_cyc)) begin
            sup_cnt <= '0;
            sup_run <= 1'b0;
        end else if (sup_cyc & (close | sup_exp | ~sup_run)) begin
            sup_cnt <= '0;
            sup_run <= 1'b1;
        end else if (sup_exp) begin
            sup_cnt <= '0;
            sup_run <= 1'b0;
        end else if (sup_run & ms_tick) begin
            sup_cnt <= sup_cnt + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // diagnostics
    // ----------------------------------------------------------------
    // new events beat a clear in the same cycle
    always_comb begin
        next_diag = rd_diag ? '0 : diag;
        if (wr_cfg & (state == ST_WAIT_CFG) & ~set_ok) next_diag[DG_SET_ERR] = 1'b1;
        if (req_take & tx_busy) next_diag[DG_OUT_OVF] = 1'b1;
        if (req_take & cmd_seen & (req_cmd != last_cmd + 8'h01)) next_diag[DG_OUT_LOSS] = 1'b1;
        if (in_ovf) next_diag[DG_IN_OVF] = 1'b1;
        if (sup_exp) begin
            next_diag[DG_IN_LOSS] = 1'b1;
            next_diag[DG_IN_TMO] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) diag <= '0;
        else diag <= next_diag;
    end

    // ----------------------------------------------------------------
    // fieldbus read path
    // ----------------------------------------------------------------
    srf_buf_mem #(.AW(AW)) u_mem (
        .clk(pclk),
        .bus(buf_bus)
    );

    logic is_hdr;
    logic [7:0] hdr_pick;
    wire [7:0] pay_idx = fb_rd_addr - 8'(HDR_LEN);
    assign buf_bus.rd_addr = {~w_bank, pay_idx[PW-1:0]};

    // two-stage read to line header up with the memory latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_hdr <= 1'b1;
            hdr_pick <= 8'h00;
            fb_rd_data <= 8'h00;
        end else begin
            is_hdr <= fb_rd_addr < 8'(HDR_LEN);
            hdr_pick <= (fb_rd_addr == 8'h00) ? hdr_state :
                (fb_rd_addr == 8'h01) ? hdr_len : hdr_cnt;
            fb_rd_data <= is_hdr ? hdr_pick : buf_bus.rd_data;
        end
    end
endmodule : srf_framer

// ---- dv/srf_props.sv ----
`timescale 1ns/1ns
// setup order and bus replies seen at the framer ports
module srf_props import srf_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status
    input wire logic led_err,
    input wire logic data_ex,
    input wire logic new_string
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded accesses
    wire acc = psel && penable;
    wire cfg_wr = acc && pwrite && paddr == ADDR_CFG;
    wire set_wr = cfg_wr || (acc && pwrite && paddr == ADDR_PRM);
    wire hdr_rd = acc && !pwrite && paddr == ADDR_HDR;
    logic seen_str;
    // counter is only meaningful once a string has closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_str <= 1'b0;
        end else if (new_string) begin
            seen_str <= 1'b1;
        end
    end
    zero_wait_a: assert property (acc |-> pready) else $error("access not answered");
    unmapped_err_a: assert property (acc && paddr > ADDR_HDR |-> pslverr)
        else $error("unmapped access without error");
    idle_rdata_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("read data outside read");
    enter_data_a: assert property ($rose(data_ex) |-> $past(cfg_wr) && !led_err)
        else $error("data exchange entered without configuration");
    leave_data_a: assert property ($fell(data_ex) |-> $past(set_wr))
        else $error("data exchange left without setup write");
    err_cause_a: assert property ($rose(led_err) |-> $past(set_wr) && !data_ex)
        else $error("error indicator without setup fault");
    string_state_a: assert property (new_string |-> data_ex)
        else $error("string closed outside data exchange");
    count_nonzero_a: assert property (seen_str && hdr_rd |-> prdata[23:16] != 8'h00)
        else $error("packet counter shows zero");
    cover property (new_string);
    cover property ($rose(data_ex));
    cover property ($rose(led_err));
endmodule : srf_props

bind srf_framer srf_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .led_err(led_err), .data_ex(data_ex), .new_string(new_string));

// ---- dv/srf_ser_model.sv ----
`timescale 1ns/1ns
// serial network side: byte source and transmit buffer state
module srf_ser_model (
    // clock
    input wire logic pclk,
    // received bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    // transmit buffer
    output logic tx_busy
);
    // quiet line at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_busy = 1'b0;
    end
    // sender gaps
    // idle data flips so a stale byte never matches by luck
    task automatic send(input logic [7:0] b, input int gap);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        repeat (gap) @(posedge pclk);
    endtask : send
endmodule : srf_ser_model

// ---- dv/srf_tb.sv ----
`timescale 1ns/1ns
module testbench import srf_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic rx_valid, tx_busy, led_err, data_ex, new_string;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] rx_data, fb_rd_addr, fb_rd_data, cmd, cnt;
    int n_errors, check_count, n;
    // ms shortened to 3 cycles so supervision fits the run
    srf_framer #(.MAX_LEN(128), .MS_CYCLES(3)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_busy(tx_busy), .fb_rd_addr(fb_rd_addr),
        .fb_rd_data(fb_rd_data), .led_err(led_err), .data_ex(data_ex), .new_string(new_string));
    srf_ser_model ser (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_busy(tx_busy));
    // 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic ok(input string w, input logic c);
        chk(w, {31'h0000_0000, c}, 32'h0000_0001);
    endtask : ok
    function automatic logic [7:0] nxt(input logic [7:0] c);
        return (c == 8'hff) ? 8'h01 : c + 8'h01;
    endfunction : nxt
    function automatic logic [31:0] prm(input logic [2:0] e, input logic f, input logic [1:0] s);
        return {19'h0_0000, s, 1'b0, f, e, 3'b100, 3'h7};
    endfunction : prm
    // one apb transfer, held until pready, one idle edge after
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic req(input logic [7:0] tmo, rlen, input logic tg, lg);
        cmd++;
        apb(1'b1, ADDR_REQ, {6'h00, lg, tg, rlen, tmo, cmd});
    endtask : req
    task automatic go(input logic [31:0] p);
        apb(1'b1, ADDR_PRM, p);
        apb(1'b1, ADDR_CFG, 32'h0003_0101);
        rd(ADDR_STAT);
        chk("stat", q, 32'h0000_0004);
    endtask : go
    task automatic wait_str();
        n = 0;
        while (new_string !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_str
    // header bytes and first payload byte of the presented string
    task automatic chk_str(input logic [7:0] st, len, first);
        logic [7:0] e [4];
        e = '{st, len, cnt, first};
        for (int i = 0; i < 4; i++) begin
            fb_rd_addr <= 8'(i);
            repeat (3) @(posedge pclk);
            chk("fb byte", {24'h00_0000, fb_rd_data}, {24'h00_0000, e[i]});
        end
    endtask : chk_str
    task automatic t_startup();
        apb(1'b1, ADDR_CFG, 32'h0003_0101);
        rd(ADDR_STAT);
        chk("stat early cfg", q, 32'h0000_0009);
        apb(1'b1, ADDR_PRM, prm(END_NONE, 1'b1, SUP_OFF));
        apb(1'b1, ADDR_CFG, 32'h0000_0101);
        rd(ADDR_STAT);
        chk("stat no setting", q, 32'h0000_0009);
        rd(ADDR_DIAG);
        chk("diag setting", q, 32'h0000_0001);
        rd(ADDR_DIAG);
        chk("diag cleared", q, 32'h0000_0000);
        rd(12'h018);
        chk("unmapped", q, 32'h0000_0000);
        go(prm(END_NONE, 1'b1, SUP_OFF));
    endtask : t_startup
    task automatic t_fixlen();
        req(8'h00, 8'h05, 1'b0, 1'b1);
        for (int i = 1; i <= 5; i++) ser.send(8'(i), 1);
        cnt = nxt(cnt);
        chk_str(8'h00, 8'h05, 8'h01);
        ser.send(8'h0b, 1);
        ser.send(8'h0c, 0);
        wait_str();
        ok("three char idle", n >= 26030 && n <= 26060);
        cnt = nxt(cnt);
        chk_str(8'h00, 8'h02, 8'h0b);
    endtask : t_fixlen
    task automatic t_endchar();
        logic [15:0] t [4];
        t = '{16'h000d, 16'h000a, 16'h0d0a, 16'h0a0d};
        for (int m = 1; m <= 4; m++) begin
            go(prm(3'(m), 1'b0, SUP_OFF));
            ser.send(8'h41, 1);
            if (m > 2) ser.send(t[m-1][15:8], 1);
            ser.send(t[m-1][7:0], 0);
            wait_str();
            ok("terminator close", n < 8);
            cnt = nxt(cnt);
            chk_str(8'h00, (m > 2) ? 8'h03 : 8'h02, 8'h41);
        end
    endtask : t_endchar
    task automatic t_timeout();
        go(prm(END_NONE, 1'b0, SUP_OFF));
        ser.send(8'h50, 1);
        ser.send(8'h51, 0);
        wait_str();
        ok("char time", n >= 8670 && n <= 8700);
        cnt = nxt(cnt);
        chk_str(8'h00, 8'h02, 8'h50);
        req(8'h03, 8'h00, 1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) ser.send(8'h50 + 8'(i), (i == 3) ? 0 : 6);
            wait_str();
            ok("gap close", n < 60);
            cnt = nxt(cnt);
            chk_str(8'h00, 8'h04, 8'h50);
            req(8'h00, 8'h00, 1'b0, 1'b0);
        end
        go(prm(END_NONE, 1'b0, SUP_OFF) | 32'(1 << PRM_TUNIT));
        req(8'h01, 8'h00, 1'b1, 1'b0);
        ser.send(8'h60, 20);
        ser.send(8'h61, 0);
        wait_str();
        ok("ten ms unit", n > 30 && n < 70);
        cnt = nxt(cnt);
        chk_str(8'h00, 8'h02, 8'h60);
    endtask : t_timeout
    task automatic t_wrap();
        go(prm(END_NONE, 1'b1, SUP_OFF));
        req(8'h00, 8'h01, 1'b0, 1'b1);
        for (int i = int'(cnt); i < 257; i++) begin
            ser.send(8'h5a, 1);
            cnt = nxt(cnt);
        end
        chk_str(8'h00, 8'h01, 8'h5a);
        rd(ADDR_HDR);
        chk("hdr reg", q, {8'h00, cnt, 8'h01, 8'h00});
    endtask : t_wrap
    task automatic t_diag();
        rd(ADDR_DIAG);
        ser.tx_busy <= 1'b1;
        req(8'h00, 8'h00, 1'b0, 1'b0);
        ser.tx_busy <= 1'b0;
        cmd++;
        req(8'h00, 8'h00, 1'b0, 1'b0);
        rd(ADDR_DIAG);
        chk("diag output", q, 32'h0000_0006);
        req(8'h00, 8'h00, 1'b0, 1'b1);
        for (int i = 0; i < 130; i++) ser.send(8'h33, (i == 129) ? 0 : 1);
        wait_str();
        cnt = nxt(cnt);
        chk_str(8'h01, 8'h80, 8'h33);
        rd(ADDR_DIAG);
        chk("diag input ovf", q, 32'h0000_0008);
        go(prm(END_CR, 1'b0, SUP_CYC));
        ser.send(8'h0d, 0);
        wait_str();
        repeat (8_900) @(posedge pclk);
        rd(ADDR_DIAG);
        chk("diag early", q, 32'h0000_0000);
        repeat (200) @(posedge pclk);
        rd(ADDR_DIAG);
        chk("diag supervision", q, 32'h0000_0030);
    endtask : t_diag
    task automatic t_reqsup();
        go(prm(END_CR, 1'b0, SUP_REQ));
        req(8'h00, 8'h00, 1'b0, 1'b0);
        ser.send(8'h0d, 1000);
        req(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (8_100) @(posedge pclk);
        rd(ADDR_DIAG);
        chk("diag answered", q, 32'h0000_0000);
        repeat (1_000) @(posedge pclk);
        rd(ADDR_DIAG);
        chk("diag no answer", q, 32'h0000_0030);
    endtask : t_reqsup
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // reset, then scenarios in order
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fb_rd_addr = 8'h00;
        {cmd, cnt} = 16'h0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_startup();
        t_fixlen();
        t_endchar();
        t_timeout();
        t_wrap();
        t_diag();
        t_reqsup();
        tally_and_finish();
    end
    // whole run is about 82k cycles
    initial begin
        #1_200_000;
        n_errors++;
        tally_and_finish();
    end
endmodule : testbench
